// ==== verilog/meter_command_and_mode_regs.sv ====
// Command decoder, serial register transfer and operating configuration register.
`timescale 1ns/1ps

module meter_command_and_mode_regs (
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic        frame_active,
  input  wire logic        bit_strobe,
  input  wire logic        bit_in,
  input  wire logic        thermal_done,
  output logic             bit_out,
  output logic             transfer_busy,
  output logic             soft_chip_reset,
  output logic             bypass_channel1_highpass,
  output logic             bypass_power_lowpass,
  output logic             disable_pulse_output,
  output logic             disable_dip_detect,
  output logic             converter_powerdown,
  output logic             thermal_conversion_start,
  output logic             half_cycle_accumulate_mode,
  output logic             short_first_input,
  output logic             short_second_input,
  output logic             swap_input_pairs,
  output logic [1:0]       waveform_rate_select,
  output logic [1:0]       waveform_source_select,
  output logic             factory_test_enable,
  output logic             waveform_sample_enable
);
  import meter_regs_pkg::*;

  // ****************************************
  // Transfer state
  // ****************************************
  xfer_state_t                 state_q, state_d;
  logic [CMD_WIDTH-1:0]        cmd_sh_q, cmd_sh_d;
  logic [5:0]                  cnt_q, cnt_d;
  logic [CMD_ADDR_W-1:0]       addr_q, addr_d;
  logic [OPCFG_WIDTH-1:0]      rd_sh_q, rd_sh_d;
  logic [OPCFG_WIDTH-1:0]      wr_sh_q, wr_sh_d;
  logic [WAIT_CNT_W-1:0]       wait_q, wait_d;
  logic [OPCFG_WIDTH-1:0]      mode_q, mode_d;
  logic                        out_q, out_d;
  logic                        srst_q, srst_d;
  logic                        busy_q, busy_d;
  logic [CMD_WIDTH-1:0]        cmd_next;
  logic [OPCFG_WIDTH-1:0]      wr_next;

  always_comb begin
    state_d  = state_q;
    cmd_sh_d = cmd_sh_q;
    cnt_d    = cnt_q;
    addr_d   = addr_q;
    rd_sh_d  = rd_sh_q;
    wr_sh_d  = wr_sh_q;
    wait_d   = wait_q;
    mode_d   = mode_q;
    out_d    = out_q;
    srst_d   = 1'b0;
    cmd_next = {cmd_sh_q[CMD_WIDTH-2:0], bit_in};
    wr_next  = {wr_sh_q[OPCFG_WIDTH-2:0], bit_in};

    // Completion of a conversion clears the start bit; a host write below wins.
    if (thermal_done) begin
      mode_d[BIT_THERM] = 1'b0;
    end

    case (state_q)
      ST_CMD: begin
        out_d = 1'b0;
        if (frame_active && bit_strobe) begin
          cmd_sh_d = cmd_next;
          cnt_d    = cnt_q + 1'b1;
          if (cnt_q == 6'(CMD_WIDTH - 1)) begin
            // Bits 5 and 6 are ignored; the host keeps them at zero.
            addr_d = cmd_next[CMD_ADDR_LSB +: CMD_ADDR_W];
            cnt_d  = reg_length(cmd_next[CMD_ADDR_LSB +: CMD_ADDR_W]);
            if (cmd_next[CMD_DIR_BIT]) begin
              state_d = ST_WRITE;
            end else begin
              state_d = ST_READ;
              rd_sh_d = (cmd_next[CMD_ADDR_LSB +: CMD_ADDR_W] == OPCFG_ADDR) ? mode_q : '0;
              // First data bit is driven as soon as the command ends.
              out_d   = (reg_length(cmd_next[CMD_ADDR_LSB +: CMD_ADDR_W]) <= 6'(OPCFG_WIDTH)) ?
                        ((cmd_next[CMD_ADDR_LSB +: CMD_ADDR_W] == OPCFG_ADDR) ? mode_q[OPCFG_WIDTH-1] : 1'b0) :
                        1'b0;
            end
          end
        end
      end
      ST_WRITE: begin
        if (bit_strobe) begin
          wr_sh_d = wr_next;
          cnt_d   = cnt_q - 1'b1;
          if (cnt_q == 6'd1) begin
            state_d = ST_CMD;
            cnt_d   = '0;
            if (addr_q == OPCFG_ADDR) begin
              mode_d = wr_next;
              if (wr_next[BIT_SOFT_RST]) begin
                // Chip reset restores defaults and blocks the port for the wait.
                mode_d  = OPCFG_RESET;
                srst_d  = 1'b1;
                wait_d  = WAIT_CNT_W'(SOFT_RST_WAIT_CYC);
                state_d = ST_HOLD;
              end
            end
          end
        end
      end
      ST_READ: begin
        if (bit_strobe) begin
          cnt_d = cnt_q - 1'b1;
          // Registers wider than the mode register lead with zero bits.
          if (cnt_q <= 6'(OPCFG_WIDTH)) begin
            rd_sh_d = {rd_sh_q[OPCFG_WIDTH-2:0], 1'b0};
          end
          out_d = (cnt_q - 6'd1 <= 6'(OPCFG_WIDTH)) && (cnt_q != 6'd1) ?
                  ((cnt_q <= 6'(OPCFG_WIDTH)) ? rd_sh_q[OPCFG_WIDTH-2] : rd_sh_q[OPCFG_WIDTH-1]) : 1'b0;
          if (cnt_q == 6'd1) begin
            state_d = ST_CMD;
            cnt_d   = '0;
            out_d   = 1'b0;
          end
        end
      end
      ST_HOLD: begin
        wait_d = wait_q - 1'b1;
        if (wait_q == WAIT_CNT_W'(1)) begin
          state_d = ST_CMD;
        end
      end
      default: begin
        state_d = ST_CMD;
      end
    endcase

    // Dropping the frame abandons any partial command or data.
    if (!frame_active && (state_q != ST_HOLD)) begin
      state_d  = ST_CMD;
      cnt_d    = '0;
      cmd_sh_d = '0;
      out_d    = 1'b0;
    end
    busy_d = (state_d == ST_HOLD);
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_q  <= ST_CMD;
      cmd_sh_q <= '0;
      cnt_q    <= '0;
      addr_q   <= '0;
      rd_sh_q  <= '0;
      wr_sh_q  <= '0;
      wait_q   <= '0;
      mode_q   <= OPCFG_RESET;
      out_q    <= 1'b0;
      srst_q   <= 1'b0;
      busy_q   <= 1'b0;
    end else begin
      state_q  <= state_d;
      cmd_sh_q <= cmd_sh_d;
      cnt_q    <= cnt_d;
      addr_q   <= addr_d;
      rd_sh_q  <= rd_sh_d;
      wr_sh_q  <= wr_sh_d;
      wait_q   <= wait_d;
      mode_q   <= mode_d;
      out_q    <= out_d;
      srst_q   <= srst_d;
      busy_q   <= busy_d;
    end
  end

  // ****************************************
  // Waveform update enable
  // ****************************************
  waveform_rate_divider u_rate (
    .clk_sys   (clk_sys),
    .rst       (rst),
    .rate_sel  (mode_q[RATE_LSB +: 2]),
    .sample_en (waveform_sample_enable)
  );

  // ****************************************
  // Outputs, all straight from flip-flops
  // ****************************************
  assign bit_out                    = out_q;
  assign transfer_busy              = busy_q;
  assign soft_chip_reset            = srst_q;
  assign bypass_channel1_highpass   = mode_q[BIT_HPF_BYP];
  assign bypass_power_lowpass       = mode_q[BIT_LPF_BYP];
  assign disable_pulse_output       = mode_q[BIT_PULSE_DIS];
  assign disable_dip_detect         = mode_q[BIT_DIP_DIS];
  assign converter_powerdown        = mode_q[BIT_CONV_PD];
  assign thermal_conversion_start   = mode_q[BIT_THERM];
  assign half_cycle_accumulate_mode = mode_q[BIT_HALF_CYC];
  assign short_first_input          = mode_q[BIT_SHORT1];
  assign short_second_input         = mode_q[BIT_SHORT2];
  assign swap_input_pairs           = mode_q[BIT_SWAP];
  assign waveform_rate_select       = mode_q[RATE_LSB +: 2];
  assign waveform_source_select     = mode_q[SRC_LSB +: 2];
  assign factory_test_enable        = mode_q[BIT_TEST];

endmodule

// ==== verilog/meter_regs_pkg.sv ====
// Constants shared by the metering command and mode register block.
package meter_regs_pkg;

  // ****************************************
  // Command byte layout
  // ****************************************
  localparam int unsigned CMD_WIDTH      = 8;
  localparam int unsigned CMD_ADDR_LSB   = 0;
  localparam int unsigned CMD_ADDR_W     = 5;
  localparam int unsigned CMD_DIR_BIT    = 7;

  // ****************************************
  // Operating configuration register
  // ****************************************
  localparam logic [4:0]  OPCFG_ADDR     = 5'h06;
  localparam int unsigned OPCFG_WIDTH    = 16;
  localparam logic [15:0] OPCFG_RESET    = 16'h000c;
  localparam int unsigned BIT_HPF_BYP    = 0;
  localparam int unsigned BIT_LPF_BYP    = 1;
  localparam int unsigned BIT_PULSE_DIS  = 2;
  localparam int unsigned BIT_DIP_DIS    = 3;
  localparam int unsigned BIT_CONV_PD    = 4;
  localparam int unsigned BIT_THERM      = 5;
  localparam int unsigned BIT_SOFT_RST   = 6;
  localparam int unsigned BIT_HALF_CYC   = 7;
  localparam int unsigned BIT_SHORT1     = 8;
  localparam int unsigned BIT_SHORT2     = 9;
  localparam int unsigned BIT_SWAP       = 10;
  localparam int unsigned RATE_LSB       = 11;
  localparam int unsigned SRC_LSB        = 13;
  localparam int unsigned BIT_TEST       = 15;

  // ****************************************
  // Waveform rate divider: MASTER_CLOCK_INPUT/128 shifted by the rate code
  // ****************************************
  localparam int unsigned RATE_BASE_LOG2 = 7;
  localparam int unsigned RATE_CNT_W     = 10;

  // ****************************************
  // Timing
  // ****************************************
  localparam int unsigned CLK_PERIOD_NS  = 50;
  localparam int unsigned SOFT_RST_WAIT_NS = 18000;
  localparam int unsigned SOFT_RST_WAIT_CYC = (SOFT_RST_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned WAIT_CNT_W     = 9;

  // ****************************************
  // Register widths in bits, by address
  // ****************************************
  localparam int unsigned LEN_W          = 6;
  localparam logic [5:0]  LEN_DEFAULT    = 6'd8;
  localparam logic [5:0]  DATA_MAX       = 6'd40;

  typedef enum logic [1:0] {ST_CMD, ST_WRITE, ST_READ, ST_HOLD} xfer_state_t;

  function automatic logic [5:0] reg_length(input logic [4:0] a);
    case (a)
      5'h05: reg_length = 6'd8;
      5'h06: reg_length = 6'd16;
      5'h07: reg_length = 6'd12;
      5'h08: reg_length = 6'd8;
      5'h09: reg_length = 6'd6;
      5'h0a: reg_length = 6'd8;
      5'h0b: reg_length = 6'd12;
      5'h0c: reg_length = 6'd8;
      5'h0d: reg_length = 6'd16;
      5'h0e: reg_length = 6'd12;
      5'h0f: reg_length = 6'd8;
      5'h10: reg_length = 6'd8;
      5'h11: reg_length = 6'd8;
      5'h12: reg_length = 6'd8;
      5'h13: reg_length = 6'd14;
      5'h14: reg_length = 6'd40;
      5'h15: reg_length = 6'd12;
      5'h1e: reg_length = 6'd6;
      5'h1f: reg_length = 6'd8;
      default: reg_length = LEN_DEFAULT;
    endcase
  endfunction

endpackage

// ==== verilog/waveform_rate_divider.sv ====
// Divider that makes the one-cycle waveform update enable.
`timescale 1ns/1ps
module waveform_rate_divider (
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic [1:0]  rate_sel,
  output logic             sample_en
);
  import meter_regs_pkg::*;

  logic [RATE_CNT_W-1:0] cnt_q;
  logic [RATE_CNT_W-1:0] cnt_d;
  logic                  en_q;
  logic                  en_d;
  logic [RATE_CNT_W-1:0] mask;

  // The period is 128 cycles times two to the rate code.
  always_comb begin
    mask  = RATE_CNT_W'((1 << (RATE_BASE_LOG2 + 32'(rate_sel))) - 1);
    cnt_d = cnt_q + 1'b1;
    en_d  = ((cnt_q & mask) == mask);
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cnt_q <= '0;
      en_q  <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      en_q  <= en_d;
    end
  end

  assign sample_en = en_q;

endmodule

// ==== testbench/host_model.sv ====
// Host model that drives the serial register port of the metering block.
`timescale 1ns/1ps
module host_model (
  input  wire logic clk_sys,
  input  wire logic bit_out,
  output logic      frame_active,
  output logic      bit_strobe,
  output logic      bit_in
);
  initial begin
    frame_active = 1'b0;
    bit_strobe   = 1'b0;
    bit_in       = 1'b0;
  end

  // ****************
  // Serial transfer
  // ****************
  // Command byte first, then exactly n data bits, both MSB first.
  task automatic xfer(input logic wr, input logic [4:0] a, input int n, input logic [39:0] d,
                      output logic [39:0] q);
    logic [7:0] c;
    c = {wr, 2'b00, a};
    q = '0;
    for (int i = 0; i < 8 + n; i++) begin
      @(posedge clk_sys);
      // One idle bit slot after the command shows that read data waits for the strobe.
      if (i == 8) begin
        bit_strobe <= 1'b0;
        @(posedge clk_sys);
      end
      if (i > 8) q = {q[38:0], bit_out};
      frame_active <= 1'b1;
      bit_strobe   <= 1'b1;
      bit_in       <= (i < 8) ? c[7 - i] : d[n + 7 - i];
    end
    @(posedge clk_sys);
    q = {q[38:0], bit_out};
    frame_active <= 1'b0;
    bit_strobe   <= 1'b0;
    // The released line shows the inverse, so a stale bit is never mistaken for data.
    bit_in       <= ~bit_in;
  endtask
endmodule

// ==== testbench/meter_command_and_mode_regs_checker.sv ====
// Assertion checker for the command and mode register block.
`timescale 1ns/1ps
module meter_command_and_mode_regs_checker (
  input wire logic       clk_sys,
  input wire logic       rst,
  input wire logic       frame_active,
  input wire logic       bit_strobe,
  input wire logic       thermal_done,
  input wire logic       bit_out,
  input wire logic       transfer_busy,
  input wire logic       soft_chip_reset,
  input wire logic       disable_pulse_output,
  input wire logic       thermal_conversion_start,
  input wire logic [1:0] waveform_rate_select,
  input wire logic       waveform_sample_enable
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);

  // ****************
  // Helper counters
  // ****************
  logic [10:0] gap_q, gap_d;
  logic [8:0]  busy_q, busy_d;
  logic [1:0]  rate_q;
  logic        seen_q, seen_d;
  // A period is only judged between two pulses at one unchanged rate.
  always_comb begin
    gap_d  = waveform_sample_enable ? 11'h001 : gap_q + 11'h001;
    busy_d = transfer_busy ? busy_q + 9'h001 : 9'h000;
    seen_d = (waveform_rate_select != rate_q || soft_chip_reset) ? 1'b0 : (waveform_sample_enable | seen_q);
  end
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      gap_q  <= 11'h000;
      busy_q <= 9'h000;
      rate_q <= 2'h0;
      seen_q <= 1'b0;
    end else begin
      gap_q  <= gap_d;
      busy_q <= busy_d;
      rate_q <= waveform_rate_select;
      seen_q <= seen_d;
    end
  end

  // ****************
  // Properties
  // ****************
  sequence quiet_s;
    !bit_strobe && !thermal_done;
  endsequence
  sequence soft_rst_s;
    soft_chip_reset && transfer_busy;
  endsequence

  cfg_stable_a: assert property (quiet_s |=> $stable({disable_pulse_output, thermal_conversion_start, waveform_rate_select}))
    else $error("mode changed without a transfer");
  soft_vals_a: assert property (soft_chip_reset |-> transfer_busy && disable_pulse_output && !thermal_conversion_start && waveform_rate_select == 2'h0)
    else $error("soft reset without defaults");
  soft_pulse_a: assert property (soft_rst_s |=> !soft_chip_reset throughout transfer_busy [*8])
    else $error("soft reset pulse or hold wrong");
  busy_cause_a: assert property ($rose(transfer_busy) |-> soft_chip_reset)
    else $error("hold without soft reset");
  hold_len_a: assert property ($fell(transfer_busy) |-> busy_q == 9'd360)
    else $error("hold length wrong");
  therm_clr_a: assert property (thermal_done && !bit_strobe && !$past(bit_strobe) |=> !thermal_conversion_start)
    else $error("conversion start not cleared");
  sample_pulse_a: assert property (waveform_sample_enable |=> !waveform_sample_enable)
    else $error("update pulse too long");
  sample_period_a: assert property (waveform_sample_enable && seen_q |-> gap_q == (11'h080 << rate_q))
    else $error("update period wrong");
  read_hold_a: assert property (frame_active && !bit_strobe |=> $stable(bit_out))
    else $error("read bit moved without a strobe");
endmodule

bind meter_command_and_mode_regs meter_command_and_mode_regs_checker i_checker (.clk_sys, .rst, .frame_active,
  .bit_strobe, .thermal_done, .bit_out, .transfer_busy, .soft_chip_reset, .disable_pulse_output,
  .thermal_conversion_start, .waveform_rate_select, .waveform_sample_enable);

// ==== testbench/meter_command_and_mode_regs_tb.sv ====
// Testbench for the command and mode register block with a serial host model.
`timescale 1ns/1ps
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin num_errors++; \
  $display("wrong value %s expected %h seen %h", n, e, g); end end
module meter_command_and_mode_regs_tb;
  import meter_regs_pkg::*;
  localparam logic [15:0] PAT [4] = '{16'h87bf, 16'h2803, 16'h5010, 16'h7824};
  logic        clk_sys, rst, thermal_done, frame_active, bit_strobe, bit_in, bit_out;
  logic        transfer_busy, soft_chip_reset, bypass_channel1_highpass, bypass_power_lowpass;
  logic        disable_pulse_output, disable_dip_detect, converter_powerdown, thermal_conversion_start;
  logic        half_cycle_accumulate_mode, short_first_input, short_second_input, swap_input_pairs;
  logic        factory_test_enable, waveform_sample_enable;
  logic [1:0]  waveform_rate_select, waveform_source_select;
  logic [15:0] mode_seen;
  logic [39:0] rd;
  int          num_errors, cmp_count, t;
  assign mode_seen = {factory_test_enable, waveform_source_select, waveform_rate_select, swap_input_pairs,
    short_second_input, short_first_input, half_cycle_accumulate_mode, 1'b0, thermal_conversion_start,
    converter_powerdown, disable_dip_detect, disable_pulse_output, bypass_power_lowpass, bypass_channel1_highpass};

  meter_command_and_mode_regs i_meter_command_and_mode_regs (.clk_sys, .rst, .frame_active, .bit_strobe,
    .bit_in, .thermal_done, .bit_out, .transfer_busy, .soft_chip_reset, .bypass_channel1_highpass,
    .bypass_power_lowpass, .disable_pulse_output, .disable_dip_detect, .converter_powerdown,
    .thermal_conversion_start, .half_cycle_accumulate_mode, .short_first_input, .short_second_input,
    .swap_input_pairs, .waveform_rate_select, .waveform_source_select, .factory_test_enable,
    .waveform_sample_enable);
  host_model i_host_model (.clk_sys, .bit_out, .frame_active, .bit_strobe, .bit_in);

  // ****************
  // Tasks
  // ****************
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic wr_mode(input logic [15:0] v);
    i_host_model.xfer(1'b1, OPCFG_ADDR, 16, {24'h0, v}, rd);
    #1;
  endtask

  task automatic rd_mode;
    i_host_model.xfer(1'b0, OPCFG_ADDR, 16, 40'h0, rd);
  endtask

  task automatic wait_pulse(output int n);
    for (n = 1; n < 3000; n++) begin
      @(posedge clk_sys);
      if (waveform_sample_enable === 1'b1) return;
    end
    num_errors++;
    end_sim();
  endtask

  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  // ****************
  // Sequence
  // ****************
  initial begin
    rst = 1'b1;
    thermal_done = 1'b0;
    num_errors = 0;
    cmp_count = 0;
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    #1;
    `CHK("reset mode", OPCFG_RESET, mode_seen)
    rd_mode();
    `CHK("reset readback", OPCFG_RESET, rd[15:0])
    $display("test reset done");
    for (int k = 0; k < 4; k++) begin
      wr_mode(PAT[k]);
      `CHK("mode outputs", PAT[k], mode_seen)
      rd_mode();
      `CHK("mode readback", PAT[k], rd[15:0])
      wait_pulse(t);
      wait_pulse(t);
      `CHK("update period", 128 << k, t)
    end
    $display("test mode bits done");
    @(posedge clk_sys);
    thermal_done <= 1'b1;
    @(posedge clk_sys);
    thermal_done <= 1'b0;
    #1;
    `CHK("conversion start", 1'b0, thermal_conversion_start)
    i_host_model.xfer(1'b1, 5'h07, 12, 40'hfff, rd);
    i_host_model.xfer(1'b0, 5'h14, 40, 40'h0, rd);
    `CHK("wide read", 40'h0, rd)
    rd_mode();
    `CHK("mode after others", 16'h7804, rd[15:0])
    $display("test framing done");
    wr_mode(16'h0040);
    `CHK("soft reset pulse", 1'b1, soft_chip_reset)
    `CHK("soft reset mode", OPCFG_RESET, mode_seen)
    for (t = 0; t < 400 && transfer_busy === 1'b1; t++) begin
      @(posedge clk_sys);
      #1;
    end
    `CHK("hold cycles", 360, t)
    rd_mode();
    `CHK("mode after soft reset", OPCFG_RESET, rd[15:0])
    $display("test soft reset done");
    end_sim();
  end
endmodule
